// file: logic/spi_port_pkg.sv
// constants and types shared by the serial control port
package spi_port_pkg;
   // ==========================================================
   // register space
   localparam int ADDR_W = 10;
   localparam int MEM_DEPTH = 563;
   localparam logic [9:0] CFG_ADDR = 10'h000;
   localparam logic [9:0] LAST_ADDR = 10'h232;
   localparam logic [9:0] UPDATE_ADDR = 10'h232;
   localparam logic [7:0] CFG_RESET = 8'h18;
   localparam logic [7:0] UPDATE_MASK = 8'h01;

   // ==========================================================
   // configuration register fields
   localparam int CFG_SDO_LO = 0;
   localparam int CFG_LSB_LO = 1;
   localparam int CFG_LSB_HI = 6;
   localparam int CFG_SDO_HI = 7;
   localparam int UPDATE_BIT = 0;

   // ==========================================================
   // instruction word layout and bit counts
   localparam int DIR_BIT = 15;
   localparam int CODE_HI = 14;
   localparam int CODE_LO = 13;
   localparam int ADDR_HI = 9;
   localparam logic [1:0] CODE_STREAM = 2'h3;
   localparam logic [3:0] INSTR_LAST_BIT = 4'hf;
   localparam logic [3:0] BYTE_LAST_BIT = 4'h7;

   // ==========================================================
   // transfer phases
   typedef enum logic [1:0] {PH_INSTR, PH_WRITE, PH_READ, PH_DONE} phase_t;
endpackage

// file: logic/level_sync.sv
// two flip-flop synchroniser for a group of levels and toggles
`timescale 1ns/1ns
module level_sync #(
   parameter int WIDTH = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   // ==========================================================
   // state
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_state_t;

   sync_state_t st_r;
   sync_state_t st_nxt;

   // only the second stage is read downstream
   always_comb
   begin
      st_nxt.meta = async_i;
      st_nxt.stable = st_r.meta;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign sync_o = st_r.stable;
endmodule

// file: logic/serial_port_instruction_addressing.sv
// serial control port target: instruction decode, address sequencing, shadow buffer
`timescale 1ns/1ns
module serial_port_instruction_addressing (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic sdio_i,
   output logic sdio_o,
   output logic sdio_oe_n_o,
   output logic sdo_o,
   output logic sdo_oe_n_o,
   output logic wr_strobe_o,
   output logic [9:0] wr_addr_o,
   output logic [7:0] wr_data_o,
   output logic update_o,
   output logic lsb_first_o,
   output logic sdo_active_o
);
   // ==========================================================
   // link-side state, clocked by the serial clock
   typedef struct packed {
      spi_port_pkg::phase_t phase;
      logic [15:0] sr;
      logic [3:0] cnt;
      logic stream;
      logic [1:0] left;
      logic [9:0] addr;
      logic [7:0] tx;
      logic [7:0] cfg;
      logic [9:0] wr_addr;
      logic [7:0] wr_data;
      logic wr_tog;
      logic upd_tog;
   } link_t;

   localparam link_t LINK_RESET = '{
      phase: spi_port_pkg::PH_INSTR,
      sr: 16'h0000,
      cnt: 4'h0,
      stream: 1'b0,
      left: 2'h0,
      addr: 10'h000,
      tx: 8'h00,
      cfg: spi_port_pkg::CFG_RESET,
      wr_addr: 10'h000,
      wr_data: 8'h00,
      wr_tog: 1'b0,
      upd_tog: 1'b0
   };

   link_t lr;
   link_t ln;

   // shadow buffer; index 0 is served by the configuration register instead
   logic [7:0] mem_r [0:spi_port_pkg::MEM_DEPTH-1];
   logic mem_we;
   logic [9:0] mem_wa;
   logic [7:0] mem_wd;

   logic cs_rose_r;
   logic out_bit_r;
   logic lsb;
   logic sdo_act;
   logic [15:0] sr_shift;
   logic [9:0] addr_step;
   logic [9:0] load_addr;
   logic [7:0] rd_byte;
   logic [7:0] rx_byte;
   logic drive;

   // ==========================================================
   // bit order and address helpers
   assign lsb = lr.cfg[spi_port_pkg::CFG_LSB_LO] | lr.cfg[spi_port_pkg::CFG_LSB_HI];
   assign sdo_act = lr.cfg[spi_port_pkg::CFG_SDO_LO] | lr.cfg[spi_port_pkg::CFG_SDO_HI];

   // lsb first fills from the top, msb first from the bottom
   assign sr_shift = lsb ? {sdio_i, lr.sr[15:1]} : {lr.sr[14:0], sdio_i};

   // decrement from 0x000 wraps to the top address so a stream can finish there
   assign addr_step = lsb ? lr.addr + 10'h001 :
                      (lr.addr == spi_port_pkg::CFG_ADDR) ? spi_port_pkg::LAST_ADDR :
                      lr.addr - 10'h001;

   assign load_addr = (lr.phase == spi_port_pkg::PH_INSTR) ? sr_shift[spi_port_pkg::ADDR_HI:0] : addr_step;

   // addresses beyond the map read as zero
   assign rd_byte = (load_addr == spi_port_pkg::CFG_ADDR) ? lr.cfg :
                    (load_addr > spi_port_pkg::LAST_ADDR) ? 8'h00 : mem_r[load_addr];

   assign rx_byte = lsb ? sr_shift[15:8] : sr_shift[7:0];

   // ==========================================================
   // cs rise marker: set while cs is high, seen by the first edge of the next frame
   always_ff @(posedge sclk_i or posedge cs_n_i or posedge rst_i)
   begin
      if (cs_n_i || rst_i)
      begin
         cs_rose_r <= 1'b1;
      end
      else
      begin
         cs_rose_r <= 1'b0;
      end
   end

   // ==========================================================
   // rising-edge sequencer
   always_comb
   begin
      spi_port_pkg::phase_t ph;
      logic [3:0] cnt;
      logic last;
      ph = lr.phase;
      cnt = lr.cnt;
      last = 1'b0;
      ln = lr;
      mem_we = 1'b0;
      mem_wa = lr.addr;
      mem_wd = rx_byte;
      if (!cs_n_i)
      begin
         // a stall is legal only on a byte boundary of the instruction or of the data of a counted transfer
         if (cs_rose_r && ((lr.cnt[2:0] != 3'h0) || (lr.phase == spi_port_pkg::PH_DONE) ||
             (lr.stream && (lr.phase != spi_port_pkg::PH_INSTR))))
         begin
            ph = spi_port_pkg::PH_INSTR;
            cnt = 4'h0;
         end
         ln.phase = ph;
         ln.sr = sr_shift;
         ln.cnt = cnt + 4'h1;
         case (ph)
            spi_port_pkg::PH_INSTR:
            begin
               if (cnt == spi_port_pkg::INSTR_LAST_BIT)
               begin
                  ln.cnt = 4'h0;
                  ln.phase = sr_shift[spi_port_pkg::DIR_BIT] ? spi_port_pkg::PH_READ :
                             spi_port_pkg::PH_WRITE;
                  ln.stream = (sr_shift[spi_port_pkg::CODE_HI:spi_port_pkg::CODE_LO] ==
                              spi_port_pkg::CODE_STREAM);
                  ln.left = sr_shift[spi_port_pkg::CODE_HI:spi_port_pkg::CODE_LO];
                  ln.addr = sr_shift[spi_port_pkg::ADDR_HI:0];
                  ln.tx = rd_byte;
               end
            end
            spi_port_pkg::PH_WRITE, spi_port_pkg::PH_READ:
            begin
               if (cnt == spi_port_pkg::BYTE_LAST_BIT)
               begin
                  ln.cnt = 4'h0;
                  if (ph == spi_port_pkg::PH_WRITE)
                  begin
                     if (lr.addr == spi_port_pkg::CFG_ADDR)
                     begin
                        ln.cfg = rx_byte;
                     end
                     else if (lr.addr <= spi_port_pkg::LAST_ADDR)
                     begin
                        mem_we = 1'b1;
                        if (lr.addr == spi_port_pkg::UPDATE_ADDR)
                        begin
                           // update bit clears itself in the buffer
                           mem_wd = rx_byte & ~spi_port_pkg::UPDATE_MASK;
                           if (rx_byte[spi_port_pkg::UPDATE_BIT])
                           begin
                              ln.upd_tog = ~lr.upd_tog;
                           end
                        end
                     end
                     if (lr.addr <= spi_port_pkg::LAST_ADDR)
                     begin
                        ln.wr_addr = lr.addr;
                        ln.wr_data = rx_byte;
                        ln.wr_tog = ~lr.wr_tog;
                     end
                  end
                  last = lr.stream ? (lr.addr == spi_port_pkg::LAST_ADDR) : (lr.left == 2'h0);
                  if (last)
                  begin
                     ln.phase = lr.stream ? spi_port_pkg::PH_DONE : spi_port_pkg::PH_INSTR;
                     ln.stream = 1'b0;
                  end
                  else
                  begin
                     ln.left = lr.stream ? lr.left : lr.left - 2'h1;
                     ln.addr = addr_step;
                     ln.tx = rd_byte;
                  end
               end
            end
            spi_port_pkg::PH_DONE:
            begin
               // further clocks are ignored until cs rises
               ln.cnt = 4'h0;
            end
            default:
            begin
               ln.phase = spi_port_pkg::PH_INSTR;
               ln.cnt = 4'h0;
            end
         endcase
      end
   end

   always_ff @(posedge sclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         lr <= LINK_RESET;
      end
      else
      begin
         lr <= ln;
      end
   end

   always_ff @(posedge sclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < spi_port_pkg::MEM_DEPTH; i++)
         begin
            mem_r[i] <= 8'h00;
         end
      end
      else if (mem_we)
      begin
         mem_r[mem_wa] <= mem_wd;
      end
   end

   // ==========================================================
   // falling-edge launch of read data
   always_ff @(negedge sclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         out_bit_r <= 1'b0;
      end
      else
      begin
         out_bit_r <= lsb ? lr.tx[lr.cnt[2:0]] : lr.tx[~lr.cnt[2:0]];
      end
   end

   // pins float whenever cs is high
   assign drive = !cs_n_i && (lr.phase == spi_port_pkg::PH_READ);
   assign sdio_o = out_bit_r;
   assign sdo_o = out_bit_r;
   assign sdio_oe_n_o = !(drive && !sdo_act);
   assign sdo_oe_n_o = !(drive && sdo_act);

   // ==========================================================
   // crossing into the system clock
   typedef struct packed {
      logic wr_seen;
      logic upd_seen;
      logic wr_strobe;
      logic upd;
      logic [9:0] wr_addr;
      logic [7:0] wr_data;
   } core_t;

   core_t cr;
   core_t cn;
   logic [3:0] synced;

   level_sync #(
      .WIDTH(4)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i({lr.wr_tog, lr.upd_tog, lsb, sdo_act}),
      .sync_o(synced)
   );

   // the held word is read only after its toggle has settled, so it is stable
   always_comb
   begin
      cn = cr;
      cn.wr_strobe = 1'b0;
      cn.upd = 1'b0;
      if (synced[3] != cr.wr_seen)
      begin
         cn.wr_seen = synced[3];
         cn.wr_strobe = 1'b1;
         cn.wr_addr = lr.wr_addr;
         cn.wr_data = lr.wr_data;
      end
      if (synced[2] != cr.upd_seen)
      begin
         cn.upd_seen = synced[2];
         cn.upd = 1'b1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cr <= '0;
      end
      else
      begin
         cr <= cn;
      end
   end

   assign wr_strobe_o = cr.wr_strobe;
   assign wr_addr_o = cr.wr_addr;
   assign wr_data_o = cr.wr_data;
   assign update_o = cr.upd;
   assign lsb_first_o = synced[1];
   assign sdo_active_o = synced[0];
endmodule

// file: tb/port_sva.sv
// port-level assertions for the serial control port target
`timescale 1ns/1ns
module port_sva (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cs_n_i,
   input wire logic sdio_oe_n_o,
   input wire logic sdo_oe_n_o,
   input wire logic wr_strobe_o,
   input wire logic [9:0] wr_addr_o,
   input wire logic [7:0] wr_data_o,
   input wire logic update_o,
   input wire logic lsb_first_o,
   input wire logic sdo_active_o
);
   // ==========================================
   // checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   a_strobe_gap: assert property (wr_strobe_o |=> !wr_strobe_o [*8])
      else $error("strobes too close");
   a_addr_range: assert property (wr_strobe_o |-> wr_addr_o <= spi_port_pkg::LAST_ADDR)
      else $error("strobe beyond last address");
   a_update_byte: assert property (update_o |-> ##[0:1] (wr_addr_o == spi_port_pkg::UPDATE_ADDR
      && wr_data_o[spi_port_pkg::UPDATE_BIT]))
      else $error("update without update byte");
   a_data_held: assert property (($changed(wr_addr_o) || $changed(wr_data_o)) |-> wr_strobe_o)
      else $error("write data moved without strobe");
   a_reset_order: assert property ($fell(rst_i) |-> (!lsb_first_o && !sdo_active_o) [*3])
      else $error("bit order not msb first after reset");
   a_idle_release: assert property (cs_n_i |-> sdio_oe_n_o && sdo_oe_n_o)
      else $error("pin driven while deselected");
   a_pin_bidir: assert property (!sdio_oe_n_o |-> !sdo_active_o && sdo_oe_n_o)
      else $error("sdio driven in wrong mode");
   a_pin_unidir: assert property (!sdo_oe_n_o |-> sdo_active_o && sdio_oe_n_o)
      else $error("sdo driven in wrong mode");
   cover property (update_o);
   cover property (lsb_first_o && wr_strobe_o);
   cover property (!sdo_oe_n_o);
   cover property (!sdio_oe_n_o);
endmodule

// file: tb/host.sv
// serial bus master model that frames and shifts bytes
`timescale 1ns/1ns
module host (
   output logic sclk_o,
   output logic cs_n_o,
   output logic sd_o,
   input wire logic sdio_i,
   input wire logic sdo_i
);
   // ==========================================
   // link clock, gated onto the pin only inside frames
   logic lclk = 1'b0;
   logic en = 1'b0;
   logic drv = 1'b0;
   logic hd = 1'b0;
   logic tgl = 1'b0;
   logic lsb = 1'b0;
   logic uni = 1'b0;
   initial cs_n_o = 1'b1;
   initial #7 forever #40 lclk = ~lclk;
   always @(negedge lclk) tgl <= ~tgl;
   assign sclk_o = lclk & en;
   // a released line never keeps the last bit
   assign sd_o = drv ? hd : tgl;
   task automatic bits(input logic [15:0] v, input int n, input logic d, output logic [15:0] r);
      int j;
      r = 16'h0000;
      for (int i = 0; i < n; i++)
      begin
         j = lsb ? i : n - 1 - i;
         @(negedge lclk);
         cs_n_o = 1'b0;
         en = 1'b1;
         drv = d;
         hd = v[j];
         // sample 20 ns after the falling edge, a quarter bit in: the target releases the pin at the closing rising edge
         #20;
         r[j] = uni ? sdo_i : sdio_i;
         @(posedge lclk);
      end
   endtask
   task automatic stop();
      @(negedge lclk);
      en = 1'b0;
      drv = 1'b0;
      cs_n_o = 1'b1;
      repeat (2) @(negedge lclk);
   endtask
   task automatic frame(input logic [15:0] ins, input int nb, input logic [7:0] wd [4],
      output logic [7:0] rd [4]);
      logic [15:0] r;
      bits(ins, 16, 1'b1, r);
      for (int b = 0; b < nb; b++)
      begin
         bits({8'h00, wd[b]}, 8, !ins[15], r);
         rd[b] = r[7:0];
      end
      stop();
   endtask
endmodule

// file: tb/tb_serial_port_instruction_addressing.sv
// self-checking bench for the serial control port target
`timescale 1ns/1ns
module tb_serial_port_instruction_addressing;
   logic clk_i = 1'b0;
   logic rst_i;
   logic sclk, cs_n, host_sd, sdio_o, sdio_oe_n_o, sdo_o, sdo_oe_n_o;
   logic wr_strobe_o, update_o, lsb_first_o, sdo_active_o;
   logic [9:0] wr_addr_o;
   logic [7:0] wr_data_o;
   logic [7:0] rd [4];
   logic [7:0] nil [4] = '{default: 8'h00};
   logic [17:0] sq [$];
   logic [17:0] eq [$];
   int errors = 0;
   int comparisons = 0;
   int upd = 0;
   wire sdio_w = sdio_oe_n_o ? host_sd : sdio_o;
   wire sdo_w = sdo_oe_n_o ? ~sdio_w : sdo_o;
   always #10 clk_i = ~clk_i;
   serial_port_instruction_addressing i_serial_port_instruction_addressing (.clk_i(clk_i), .rst_i(rst_i),
      .sclk_i(sclk), .cs_n_i(cs_n), .sdio_i(sdio_w), .sdio_o(sdio_o), .sdio_oe_n_o(sdio_oe_n_o),
      .sdo_o(sdo_o), .sdo_oe_n_o(sdo_oe_n_o), .wr_strobe_o(wr_strobe_o), .wr_addr_o(wr_addr_o),
      .wr_data_o(wr_data_o), .update_o(update_o), .lsb_first_o(lsb_first_o), .sdo_active_o(sdo_active_o));
   host i_host (.sclk_o(sclk), .cs_n_o(cs_n), .sd_o(host_sd), .sdio_i(sdio_w), .sdo_i(sdo_w));
   always @(posedge clk_i)
   begin
      if (wr_strobe_o === 1'b1)
         sq.push_back({wr_addr_o, wr_data_o});
      if (update_o === 1'b1)
         upd++;
   end
   // ==========================================
   // compares
   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr_chk();
      repeat (10) @(posedge clk_i);
      chk(18'(sq.size()), 18'(eq.size()));
      foreach (eq[i]) chk(sq[i], eq[i]);
      sq.delete();
   endtask
   task automatic rd_chk(input int n, input logic [7:0] e [4]);
      for (int k = 0; k < n; k++) chk({10'h000, rd[k]}, {10'h000, e[k]});
   endtask
   // ==========================================
   // scenarios
   task automatic t_reset();
      chk({16'h0000, lsb_first_o, sdo_active_o}, 18'h0_0000);
      i_host.frame(16'h8000, 1, nil, rd);
      chk({10'h000, rd[0]}, {10'h000, spi_port_pkg::CFG_RESET});
   endtask
   task automatic t_counted();
      i_host.frame(16'h4012, 3, '{8'ha1, 8'hb2, 8'hc3, 8'hd4}, rd);
      eq = '{18'h0_12a1, 18'h0_11b2, 18'h0_10c3};
      wr_chk();
      for (int c = 0; c < 2; c++)
      begin
         i_host.frame({1'b0, c[1:0], 13'h0100}, c + 1, '{8'h11, 8'h22, 8'h33, 8'h44}, rd);
         eq = '{18'h1_0011};
         if (c == 1)
            eq.push_back(18'h0_ff22);
         wr_chk();
      end
      // upper address bits set on purpose: they must be ignored
      i_host.frame(16'hdc12, 3, nil, rd);
      rd_chk(3, '{8'ha1, 8'hb2, 8'hc3, 8'h00});
   endtask
   task automatic t_stream_msb();
      i_host.frame(16'h6001, 4, '{8'h5a, 8'h18, 8'h01, 8'h77}, rd);
      eq = '{18'h0_015a, 18'h0_0018, 18'h2_3201};
      wr_chk();
      chk(18'(upd), 18'h0_0001);
   endtask
   task automatic t_lsb();
      i_host.frame(16'h0000, 1, '{8'h42, 8'h00, 8'h00, 8'h00}, rd);
      repeat (10) @(posedge clk_i);
      chk({17'h0_0000, lsb_first_o}, 18'h0_0001);
      i_host.lsb = 1'b1;
      i_host.frame(16'h6230, 4, '{8'h0f, 8'hf0, 8'h00, 8'h99}, rd);
      eq = '{18'h0_0042, 18'h2_300f, 18'h2_31f0, 18'h2_3200};
      wr_chk();
      i_host.frame(16'ha230, 2, nil, rd);
      rd_chk(2, '{8'h0f, 8'hf0, 8'h00, 8'h00});
      i_host.frame(16'h0000, 1, '{8'h18, 8'h00, 8'h00, 8'h00}, rd);
      i_host.lsb = 1'b0;
      eq = '{18'h0_0018};
      wr_chk();
      chk({17'h0_0000, lsb_first_o}, 18'h0_0000);
   endtask
   task automatic t_abort();
      logic [15:0] r;
      i_host.bits(16'h0020, 16, 1'b1, r);
      i_host.bits(16'h00ff, 4, 1'b1, r);
      i_host.stop();
      i_host.bits(16'h0022, 16, 1'b1, r);
      i_host.bits(16'h0055, 8, 1'b1, r);
      i_host.frame(16'h0023, 1, '{8'h3c, 8'h00, 8'h00, 8'h00}, rd);
      eq = '{18'h0_2255, 18'h0_233c};
      wr_chk();
   endtask
   task automatic t_unidir();
      i_host.frame(16'h0000, 1, '{8'h81, 8'h00, 8'h00, 8'h00}, rd);
      repeat (10) @(posedge clk_i);
      chk({17'h0_0000, sdo_active_o}, 18'h0_0001);
      i_host.uni = 1'b1;
      i_host.frame(16'h8012, 1, nil, rd);
      rd_chk(1, '{8'ha1, 8'h00, 8'h00, 8'h00});
      i_host.frame(16'h0000, 1, '{8'h18, 8'h00, 8'h00, 8'h00}, rd);
      i_host.uni = 1'b0;
      eq = '{18'h0_0081, 18'h0_0018};
      wr_chk();
   endtask
   task automatic conclude();
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      // an initialiser raises no edge, so the serial-side async reset would never fire
      rst_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      t_reset();
      t_counted();
      t_stream_msb();
      t_lsb();
      t_abort();
      t_unidir();
      conclude();
   end
   // about nine times the expected run length
   initial
   begin
      #400000;
      errors++;
      conclude();
   end
endmodule
bind serial_port_instruction_addressing port_sva i_port_sva (.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i),
   .sdio_oe_n_o(sdio_oe_n_o), .sdo_oe_n_o(sdo_oe_n_o), .wr_strobe_o(wr_strobe_o), .wr_addr_o(wr_addr_o),
   .wr_data_o(wr_data_o), .update_o(update_o), .lsb_first_o(lsb_first_o), .sdo_active_o(sdo_active_o));
